// ===== tppmd_host.sv
`timescale 1ns/100ps
// Notes on behaviour
// - primary header identity fields fixed
// - sequence flags 11, ground source, counter
// - packet length field is seven
// - private type, subtype, zero pad byte
// - subtype 0x66 means mirror move
// - mirror move acknowledge field is 0001
// - mirror data must be 1 to 3
// - service version 0, checksum flag, trailing checksum
// - no pulse command with spectrometer unpowered
// - no pulse command during scan integration
// - subtype 0x0D means pulse position
module tppmd_host
  import tppmd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_kind,
  input wire logic [15:0] i_cmd_data,
  output logic o_cmd_ready,
  output logic o_cmd_reject,
  input wire logic i_spec_powered,
  input wire logic i_scan_integrating,
  output logic [7:0] o_tx_data,
  output logic o_tx_valid,
  output logic o_tx_last,
  input wire logic i_tx_ready,
  output logic o_busy,
  output logic [10:0] o_seq_count,
  output logic [15:0] o_pulse_position_param,
  output logic [15:0] o_mirror_target_param
);

  // ********************************************************
  // declarations
  // ********************************************************
  tppmd_byte_if b ();

  tppmd_state_e state;
  tppmd_state_e next_state;
  logic [3:0] idx;
  logic [3:0] next_idx;
  logic [95:0] frame;
  logic [95:0] next_frame;
  logic [10:0] seq;
  logic [10:0] next_seq;
  logic [15:0] pulse_position_param;
  logic [15:0] next_pulse_position_param;
  logic [15:0] mirror_target_param;
  logic [15:0] next_mirror_target_param;
  logic reject;
  logic next_reject;
  logic [15:0] crc;
  logic cmd_ok;
  logic take;
  logic step;
  logic mirror_in_range;
  logic pulse_allowed;

  // ********************************************************
  // helpers
  // ********************************************************
  // byte i counted from the top of the frame, never past the last index
  function automatic logic [7:0] frame_byte(
    input logic [95:0] f,
    input logic [3:0] i
  );
    logic [6:0] pos;
    pos = 7'(i) << 3;
    return f[7'd95 - pos -: 8];
  endfunction

  // one place decides which command a kind bit names
  function automatic logic is_mirror(
    input logic kind
  );
    return kind == TPPMD_CMD_MIRROR;
  endfunction

  // twelve bytes ahead of the checksum, most significant first:
  //   0-1   version, type, header flag, process id, category
  //   2-3   sequence flags, ground source, counter
  //   4-5   packet length
  //   6     service version, checksum flag, acknowledge
  //   7-9   packet type, subtype, pad
  //   10-11 application data
  function automatic logic [95:0] build_frame(
    input logic kind,
    input logic [10:0] count,
    input logic [15:0] value
  );
    logic [3:0] ack;
    logic [7:0] sub;
    logic [15:0] ident;
    logic [15:0] count_word;
    logic [7:0] service;
    ack = is_mirror(kind) ? TPPMD_ACK_MIRROR
                          : TPPMD_ACK_PULSE;
    sub = is_mirror(kind) ? TPPMD_SUB_MIRROR
                          : TPPMD_SUB_PULSE;
    ident = {TPPMD_VERSION, TPPMD_TYPE, TPPMD_DFH_FLAG,
             TPPMD_APID, TPPMD_CATEGORY};
    count_word = {TPPMD_SEQ_FLAGS, TPPMD_SEQ_SOURCE, count};
    service = {TPPMD_PUS_VERSION, TPPMD_CHECKSUM_FLAG, ack};
    return {
      ident, count_word, TPPMD_PKT_LENGTH,
      service, TPPMD_PKT_TYPE, sub, TPPMD_PAD,
      value
    };
  endfunction

  // ********************************************************
  // command acceptance
  // ********************************************************
  // a refused command is consumed and flagged, so the user never
  // stalls waiting for power or for a scan to finish
  assign mirror_in_range = (i_cmd_data >= TPPMD_MIRROR_MIN) &&
                           (i_cmd_data <= TPPMD_MIRROR_MAX);
  // spectrometer state is judged at the take edge only; a change
  // while the packet is on its way does not recall it
  assign pulse_allowed = i_spec_powered &&
                         !i_scan_integrating;

  always_comb begin
    if (is_mirror(i_cmd_kind)) begin
      cmd_ok = mirror_in_range;
    end else begin
      cmd_ok = pulse_allowed;
    end
  end

  // ready only when idle, so every take starts from idle
  assign o_cmd_ready = (state == TPPMD_S_IDLE);
  assign take = i_cmd_valid && o_cmd_ready;

  // ********************************************************
  // frame sequencer
  // ********************************************************
  // a byte leaves the sequencer whenever the output stage has room
  assign step = b.valid && b.ready;

  always_comb begin
    next_state = state;
    next_idx = idx;
    unique case (state)
      TPPMD_S_IDLE: begin
        // a refused command leaves the sequencer idle
        if (take && cmd_ok) begin
          next_idx = TPPMD_IDX_FIRST;
          next_state = TPPMD_S_HDR;
        end
      end
      TPPMD_S_HDR: begin
        // idx moves only on a taken byte, so a stall repeats nothing
        if (step) begin
          if (idx == TPPMD_IDX_LAST) begin
            next_state = TPPMD_S_CRC_HI;
          end else begin
            next_idx = idx + TPPMD_IDX_STEP;
          end
        end
      end
      TPPMD_S_CRC_HI: begin
        if (step) begin
          next_state = TPPMD_S_CRC_LO;
        end
      end
      TPPMD_S_CRC_LO: begin
        if (step) begin
          next_state = TPPMD_S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= TPPMD_S_IDLE;
      idx <= TPPMD_IDX_FIRST;
    end else begin
      state <= next_state;
      idx <= next_idx;
    end
  end

  // ********************************************************
  // command store
  // ********************************************************
  // values are stored at acceptance, not when the packet leaves, so
  // the mirrors follow the command order even under back-pressure
  always_comb begin
    next_frame = frame;
    next_seq = seq;
    next_pulse_position_param = pulse_position_param;
    next_mirror_target_param = mirror_target_param;
    next_reject = 1'b0;
    if (take && cmd_ok) begin
      next_frame = build_frame(i_cmd_kind, seq, i_cmd_data);
      next_seq = seq + TPPMD_SEQ_STEP;
      if (is_mirror(i_cmd_kind)) begin
        next_mirror_target_param = i_cmd_data;
      end else begin
        next_pulse_position_param = i_cmd_data;
      end
    end else if (take) begin
      // answered by a single reject pulse, nothing is sent
      next_reject = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      frame <= '0;
      seq <= TPPMD_SEQ_INIT;
      // both views restart at the defaults the device itself assumes
      pulse_position_param <= TPPMD_PULSE_DEFAULT;
      mirror_target_param <= TPPMD_MIRROR_SPACE;
      reject <= 1'b0;
    end else begin
      frame <= next_frame;
      seq <= next_seq;
      pulse_position_param <= next_pulse_position_param;
      mirror_target_param <= next_mirror_target_param;
      reject <= next_reject;
    end
  end

  // ********************************************************
  // byte stream towards the link
  // ********************************************************
  // checksum bytes are taken from the checker one cycle after the
  // last header byte, by which time it holds the final value
  always_comb begin
    b.valid = 1'b0;
    b.calc = 1'b0;
    b.first = 1'b0;
    b.last = 1'b0;
    b.data = 8'h00;
    unique case (state)
      TPPMD_S_IDLE: begin
        b.valid = 1'b0;
      end
      TPPMD_S_HDR: begin
        b.valid = 1'b1;
        b.calc = 1'b1;
        b.first = (idx == TPPMD_IDX_FIRST);
        b.data = frame_byte(frame, idx);
      end
      TPPMD_S_CRC_HI: begin
        b.valid = 1'b1;
        b.data = crc[15:8];
      end
      TPPMD_S_CRC_LO: begin
        b.valid = 1'b1;
        b.last = 1'b1;
        b.data = crc[7:0];
      end
    endcase
  end

  // checksum runs beside the stream rather than over the stored frame
  tppmd_crc u_crc (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .b(b.mon),
    .o_crc(crc)
  );

  // one-byte holding stage; its ready paces the sequencer and keeps
  // the last checksum byte from being overwritten by a new packet
  tppmd_tx_stage u_tx (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .b(b.snk),
    .o_tx_data(o_tx_data),
    .o_tx_valid(o_tx_valid),
    .o_tx_last(o_tx_last),
    .i_tx_ready(i_tx_ready)
  );

  // ********************************************************
  // status
  // ********************************************************
  // the device reports no pulse position, so the host keeps its own
  // view of what was last commanded; it starts at the device default
  assign o_cmd_reject = reject;
  // busy holds until the link has taken the final byte
  assign o_busy = (state != TPPMD_S_IDLE) || o_tx_valid;
  assign o_seq_count = seq;
  assign o_pulse_position_param = pulse_position_param;
  assign o_mirror_target_param = mirror_target_param;

endmodule

// ===== tppmd_pkg.sv
package tppmd_pkg;

  // ********************************************************
  // packet primary header fields
  // ********************************************************
  localparam logic [2:0] TPPMD_VERSION = 3'h0;
  localparam logic TPPMD_TYPE = 1'h1;
  localparam logic TPPMD_DFH_FLAG = 1'h1;
  localparam logic [6:0] TPPMD_APID = 7'h47;
  localparam logic [3:0] TPPMD_CATEGORY = 4'hC;
  localparam logic [1:0] TPPMD_SEQ_FLAGS = 2'h3;
  localparam logic [2:0] TPPMD_SEQ_SOURCE = 3'h0;
  localparam int TPPMD_SEQ_W = 11;
  localparam logic [10:0] TPPMD_SEQ_INIT = 11'h000;
  localparam logic [10:0] TPPMD_SEQ_STEP = 11'h001;
  localparam logic [15:0] TPPMD_PKT_LENGTH = 16'h0007;

  // ********************************************************
  // secondary header fields
  // ********************************************************
  localparam logic [2:0] TPPMD_PUS_VERSION = 3'h0;
  localparam logic TPPMD_CHECKSUM_FLAG = 1'h1;
  localparam logic [3:0] TPPMD_ACK_PULSE = 4'h9;
  localparam logic [3:0] TPPMD_ACK_MIRROR = 4'h1;
  localparam logic [7:0] TPPMD_PKT_TYPE = 8'hC0;
  localparam logic [7:0] TPPMD_SUB_PULSE = 8'h0D;
  localparam logic [7:0] TPPMD_SUB_MIRROR = 8'h66;
  localparam logic [7:0] TPPMD_PAD = 8'h00;

  // ********************************************************
  // application data values
  // ********************************************************
  localparam logic [15:0] TPPMD_MIRROR_MIN = 16'h0001;
  localparam logic [15:0] TPPMD_MIRROR_MAX = 16'h0003;
  localparam logic [15:0] TPPMD_MIRROR_SPACE = 16'h0001;
  localparam logic [15:0] TPPMD_PULSE_DEFAULT = 16'h019A;

  // ********************************************************
  // checksum and framing
  // ********************************************************
  localparam logic [15:0] TPPMD_CRC_INIT = 16'hFFFF;
  localparam logic [15:0] TPPMD_CRC_POLY = 16'h1021;
  localparam logic [3:0] TPPMD_IDX_FIRST = 4'h0;
  localparam logic [3:0] TPPMD_IDX_LAST = 4'hB;
  localparam logic [3:0] TPPMD_IDX_STEP = 4'h1;
  localparam logic TPPMD_CMD_PULSE = 1'b0;
  localparam logic TPPMD_CMD_MIRROR = 1'b1;

  typedef enum logic [3:0] {
    TPPMD_S_IDLE = 4'h1,
    TPPMD_S_HDR = 4'h2,
    TPPMD_S_CRC_HI = 4'h4,
    TPPMD_S_CRC_LO = 4'h8
  } tppmd_state_e;

endpackage

// ===== tppmd_byte_if.sv
`timescale 1ns/100ps
interface tppmd_byte_if;
  logic [7:0] data;
  logic valid;
  logic ready;
  logic calc;
  logic first;
  logic last;

  modport src (
    output data, valid, calc, first, last,
    input ready
  );
  modport snk (
    input data, valid, calc, first, last,
    output ready
  );
  modport mon (
    input data, valid, ready, calc, first, last
  );
endinterface

// ===== tppmd_crc.sv
`timescale 1ns/100ps
module tppmd_crc
  import tppmd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  tppmd_byte_if.mon b,
  output logic [15:0] o_crc
);

  logic [15:0] crc;
  logic [15:0] next_crc;

  function automatic logic [15:0] crc_byte(
    input logic [15:0] c_in,
    input logic [7:0] d
  );
    logic [15:0] c;
    c = c_in ^ {d, 8'h00};
    for (int k = 0; k < 8; k++) begin
      if (c[15]) begin
        c = {c[14:0], 1'b0} ^ TPPMD_CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  // first byte restarts from the seed, so no clear pulse is needed
  always_comb begin
    next_crc = crc;
    if (b.valid && b.ready && b.calc) begin
      next_crc = crc_byte(b.first ? TPPMD_CRC_INIT : crc, b.data);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      crc <= TPPMD_CRC_INIT;
    end else begin
      crc <= next_crc;
    end
  end

  assign o_crc = crc;

endmodule

// ===== tppmd_tx_stage.sv
`timescale 1ns/100ps
module tppmd_tx_stage
  import tppmd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  tppmd_byte_if.snk b,
  output logic [7:0] o_tx_data,
  output logic o_tx_valid,
  output logic o_tx_last,
  input wire logic i_tx_ready
);

  logic full;
  logic next_full;
  logic [7:0] data;
  logic [7:0] next_data;
  logic last;
  logic next_last;

  // link back-pressure reaches the frame sequencer through ready
  assign b.ready = !full || i_tx_ready;

  always_comb begin
    next_full = full;
    next_data = data;
    next_last = last;
    if (b.ready) begin
      next_full = b.valid;
      if (b.valid) begin
        next_data = b.data;
        next_last = b.last;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      full <= 1'b0;
      data <= 8'h00;
      last <= 1'b0;
    end else begin
      full <= next_full;
      data <= next_data;
      last <= next_last;
    end
  end

  assign o_tx_data = data;
  assign o_tx_valid = full;
  assign o_tx_last = last;

endmodule

// ===== tppmd_host_checker.sv
`timescale 1ns/100ps
module tppmd_host_checker (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_kind,
  input wire logic [15:0] i_cmd_data,
  input wire logic o_cmd_ready,
  input wire logic o_cmd_reject,
  input wire logic i_spec_powered,
  input wire logic i_scan_integrating,
  input wire logic [7:0] o_tx_data,
  input wire logic o_tx_valid,
  input wire logic o_tx_last,
  input wire logic i_tx_ready,
  input wire logic [10:0] o_seq_count
);
  // ****
  // command and link checks
  // ****
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  wire tk = i_cmd_valid && o_cmd_ready;
  logic [3:0] nb;
  // bytes taken in the current packet
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) nb <= 4'h0;
    else if (o_tx_valid && i_tx_ready) nb <= o_tx_last ? 4'h0 : nb + 4'h1;
  end
  chk_tx_hold:
    assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid
      && $stable(o_tx_data) && $stable(o_tx_last)) else $error("stall");
  chk_send_now:
    assert property (tk ##1 (!o_cmd_reject && (!o_tx_valid || i_tx_ready))
      |=> o_tx_valid && o_tx_data == 8'h1C) else $error("late start");
  chk_busy_span:
    assert property (tk ##1 !o_cmd_reject |-> !o_cmd_ready [*8])
      else $error("early ready");
  chk_mirror_bad:
    assert property (tk && i_cmd_kind && (i_cmd_data == 16'h0000
      || i_cmd_data > 16'h0003) |=> o_cmd_reject) else $error("range");
  chk_mirror_good:
    assert property (tk && i_cmd_kind && i_cmd_data != 16'h0000
      && i_cmd_data < 16'h0004 |=> !o_cmd_reject) else $error("refused");
  chk_pulse_unpow:
    assert property (tk && !i_cmd_kind && !i_spec_powered |=> o_cmd_reject)
      else $error("unpowered");
  chk_pulse_integ:
    assert property (tk && !i_cmd_kind && i_scan_integrating
      |=> o_cmd_reject) else $error("integrating");
  chk_reject_quiet:
    assert property (tk ##1 (o_cmd_reject && !o_tx_valid) |=> !o_tx_valid)
      else $error("refused sent");
  chk_seq_step:
    assert property ($changed(o_seq_count)
      |-> o_seq_count == $past(o_seq_count) + 11'h001) else $error("seq");
  chk_pkt_len:
    assert property (o_tx_valid && i_tx_ready && o_tx_last |-> nb == 4'hD)
      else $error("length");
endmodule
bind tppmd_host tppmd_host_checker chk (.i_clk(i_clk),
  .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid), .i_cmd_kind(i_cmd_kind),
  .i_cmd_data(i_cmd_data), .o_cmd_ready(o_cmd_ready),
  .o_cmd_reject(o_cmd_reject), .i_spec_powered(i_spec_powered),
  .i_scan_integrating(i_scan_integrating), .o_tx_data(o_tx_data),
  .o_tx_valid(o_tx_valid), .o_tx_last(o_tx_last),
  .i_tx_ready(i_tx_ready), .o_seq_count(o_seq_count));

// ===== tppmd_spec_model.sv
`timescale 1ns/100ps
module tppmd_spec_model (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_data,
  input wire logic i_valid,
  input wire logic i_last,
  input wire logic i_hold,
  output logic o_ready,
  output logic o_got,
  output logic [31:0] o_rec,
  output logic [15:0] o_pulse,
  output logic [15:0] o_mirror
);
  // ****
  // receiving instrument
  // ****
  logic [3:0] idx;
  logic [7:0] b [12];
  logic [7:0] hi;
  logic [15:0] crc, pulse, mirror, dv;
  logic [10:0] seq;
  logic ok;
  function automatic logic [15:0] crc_b(input logic [15:0] c,
    input logic [7:0] d);
    c = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) c = {c[14:0], 1'b0} ^ (c[15] ? 16'h1021 : 0);
    return c;
  endfunction
  assign o_ready = !i_hold;
  assign dv = {b[10], b[11]};
  assign o_pulse = pulse;
  assign o_mirror = mirror;
  assign ok = idx == 4'hD && {hi, i_data} == crc
    && b[0] == 8'h1C && b[1] == 8'h7C && b[2][7:3] == 5'h18
    && {b[2][2:0], b[3]} == seq && {b[4], b[5]} == 16'h0007
    && b[6][7:4] == 4'h1 && b[7] == 8'hC0 && b[9] == 8'h00
    && ((b[8] == 8'h0D && b[6][3:0] == 4'h9)
    || (b[8] == 8'h66 && b[6][3:0] == 4'h1
    && dv != 16'h0000 && dv < 16'h0004));
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      idx <= 4'h0;
      crc <= 16'hFFFF;
      o_got <= 1'b0;
      o_rec <= 32'h0;
      pulse <= 16'h019A;
      mirror <= 16'h0001;
      seq <= 11'h000;
    end else begin
      o_got <= 1'b0;
      if (i_valid && o_ready) begin
        idx <= idx + 4'h1;
        if (idx < 4'hC) b[idx] <= i_data;
        if (idx < 4'hC) crc <= crc_b(crc, i_data);
        if (idx == 4'hC) hi <= i_data;
        if (i_last) begin
          idx <= 4'h0;
          crc <= 16'hFFFF;
          o_got <= 1'b1;
          o_rec <= {b[8], dv, seq[6:0], ok};
          // malformed packets change nothing
          if (ok) seq <= seq + 11'h001;
          if (ok && b[8] == 8'h0D) pulse <= dv;
          if (ok && b[8] == 8'h66) mirror <= dv;
        end
      end
    end
  end
endmodule

// ===== tppmd_host_bench.sv
`timescale 1ns/100ps
module tppmd_host_bench;
  // ****
  // stimulus and scoreboard
  // ****
  logic clk, rstn, cv, ck, pw, ig, hold, slow, trdy;
  logic rdy, rej, tv, tl, busy, got;
  logic [7:0] td;
  logic [10:0] seq;
  logic [15:0] cd, pp, mt, mp, mm;
  logic [31:0] rs, v, rec;
  logic [6:0] es;
  logic [31:0] q [$];
  int miscompares, comparisons, cyc;
  tppmd_host dut (.i_clk(clk), .i_resetn(rstn), .i_cmd_valid(cv),
    .i_cmd_kind(ck), .i_cmd_data(cd), .o_cmd_ready(rdy),
    .o_cmd_reject(rej), .i_spec_powered(pw), .i_scan_integrating(ig),
    .o_tx_data(td), .o_tx_valid(tv), .o_tx_last(tl), .i_tx_ready(trdy),
    .o_busy(busy), .o_seq_count(seq), .o_pulse_position_param(pp),
    .o_mirror_target_param(mt));
  tppmd_spec_model pm (.i_clk(clk), .i_resetn(rstn), .i_data(td),
    .i_valid(tv), .i_last(tl), .i_hold(hold), .o_ready(trdy),
    .o_got(got), .o_rec(rec), .o_pulse(mp), .o_mirror(mm));
  function logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // the note is queued before the take so the watcher never runs ahead
  task cmd(input logic k, input logic [15:0] d, input logic p, g);
    if (k ? (d != 0 && d < 4) : (p && !g)) begin
      q.push_back({k ? 8'h66 : 8'h0D, d, es, 1'b1});
      es++;
    end else q.push_back(32'hFFFFFFFF);
    @(posedge clk);
    cv <= 1'b1;
    ck <= k;
    cd <= d;
    pw <= p;
    ig <= g;
    do @(negedge clk); while (rdy !== 1'b1);
    @(posedge clk);
    cv <= 1'b0;
  endtask
  task drain;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((q.size() != 0 || busy !== 1'b0) && n < 3000);
    check("drain", 32'(q.size()), 32'h0);
  endtask
  task reset_vals;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check("pulse", {16'h0, pp}, 32'h019A);
    check("mirror", {16'h0, mt}, 32'h0001);
    check("seq", {21'h0, seq}, 32'h0);
    check("spec pulse", {16'h0, mp}, 32'h019A);
    check("spec mirror", {16'h0, mm}, 32'h0001);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) hold <= slow && (rnd() > 32'h7FFFFFFF);
  always @(negedge clk) begin
    if (rstn && got === 1'b1) check("packet", rec, q.pop_front());
    if (rstn && rej === 1'b1) check("refuse", 32'hFFFFFFFF, q.pop_front());
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim;
    end
  end
  initial begin
    rs = 32'hDB718C9F;
    {rstn, cv, ck, cd, pw, ig, hold, slow, es, cyc} = '0;
    pw = 1'b1;
    miscompares = 0;
    comparisons = 0;
    reset_vals();
    $display("test reset done");
    v = rnd();
    cmd(1'b0, v[15:0], 1'b1, 1'b0);
    for (int m = 1; m < 4; m++) cmd(1'b1, 16'(m), 1'b1, 1'b0);
    drain();
    check("stored", {16'h0, pp}, {16'h0, v[15:0]});
    check("target", {16'h0, mt}, 32'h0003);
    check("held", {16'h0, mp}, {16'h0, v[15:0]});
    check("moved", {16'h0, mm}, 32'h0003);
    $display("test codes done");
    cmd(1'b1, 16'h0000, 1'b1, 1'b0);
    cmd(1'b1, v[15:0] | 16'h0004, 1'b1, 1'b0);
    cmd(1'b0, 16'h0001, 1'b0, 1'b0);
    cmd(1'b0, 16'h0002, 1'b1, 1'b1);
    drain();
    check("kept", {16'h0, pp}, {16'h0, v[15:0]});
    check("spec kept", {16'h0, mp}, {16'h0, v[15:0]});
    $display("test refusals done");
    slow <= 1'b1;
    repeat (6) begin
      v = rnd();
      cmd(v[16], v[16] ? 16'(v[1:0] | 2'h1) : v[15:0], 1'b1, 1'b0);
    end
    drain();
    slow <= 1'b0;
    $display("test stalls done");
    cmd(1'b0, 16'h01FE, 1'b1, 1'b0);
    repeat (5) @(posedge clk);
    rstn <= 1'b0;
    q.delete();
    es = 7'h0;
    reset_vals();
    $display("test restart done");
    end_sim();
  end
endmodule
